//--- src/tlc_pkg.sv
// constants for the transformer loss compensation datapath
// assumes a 16-bit register port and signed 24-bit power readings
package tlc_pkg;
    localparam int DW        = 16;  // register and ratio width
    localparam int PW        = 24;  // signed power reading width
    localparam int TW        = 26;  // phase-sum width
    localparam int AW        = 4;   // register index width
    localparam int PHW       = 2;   // phase index width
    localparam int FRAC      = 14;  // ratio fraction bits, q2.14
    localparam int CFRAC     = 16;  // coefficient fraction bits, q0.16
    localparam int LAT       = 4;   // input to corrected output, cycles
    // register indices
    localparam logic [AW-1:0] A_CTRL     = 4'h0;
    localparam logic [AW-1:0] A_IRON_W   = 4'h1;
    localparam logic [AW-1:0] A_COPPER_W = 4'h2;
    localparam logic [AW-1:0] A_IRON_V   = 4'h3;
    localparam logic [AW-1:0] A_COPPER_V = 4'h4;
    localparam logic [AW-1:0] A_RECIP_V  = 4'h5;
    localparam logic [AW-1:0] A_RECIP_I  = 4'h6;
    localparam logic [AW-1:0] A_FSVA     = 4'h7;
    localparam logic [AW-1:0] A_STATUS   = 4'h8;
    // control bits
    localparam int C_IRON   = 0;
    localparam int C_COPPER = 1;
    localparam int C_ADD    = 2;
    localparam int C_FLIP   = 3;
    localparam int C_TEST   = 4;
    localparam int C_BITS   = 5;
    localparam logic [C_BITS-1:0] CTRL_RST = 5'h00;
    localparam logic [DW-1:0] RECIP_RST = 16'h4000;  // ratio of one
    localparam logic [DW-1:0] ZERO_W    = 16'h0000;
    localparam logic [DW-1:0] SAT16     = 16'hFFFF;
endpackage

//--- src/tlc_core.sv
// per-phase loss compensation pipeline with its register file
// assumes one-second phase readings arrive as a stream from logic
// on mclk; software reaches registers through a plain strobe port
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps

module tlc_core (
    input  wire logic                     mclk,
    input  wire logic                     nrst,
    input  wire logic [tlc_pkg::AW-1:0]   reg_addr,
    input  wire logic [tlc_pkg::DW-1:0]   reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [tlc_pkg::DW-1:0]   reg_rdata,
    input  wire logic                     in_valid,
    input  wire logic [tlc_pkg::PHW-1:0]  in_phase,
    input  wire logic                     in_last,
    input  wire logic [tlc_pkg::DW-1:0]   in_volts,
    input  wire logic [tlc_pkg::DW-1:0]   in_amps,
    input  wire logic [tlc_pkg::PW-1:0]   in_watts,
    input  wire logic [tlc_pkg::PW-1:0]   in_vars,
    output logic                          out_valid,
    output logic      [tlc_pkg::PHW-1:0]  out_phase,
    output logic                          out_last,
    output logic      [tlc_pkg::PW-1:0]   out_watts,
    output logic      [tlc_pkg::PW-1:0]   out_vars,
    output logic                          tot_valid,
    output logic      [tlc_pkg::TW-1:0]   tot_watts,
    output logic      [tlc_pkg::TW-1:0]   tot_vars
);
    localparam int DW = tlc_pkg::DW;
    localparam int PW = tlc_pkg::PW;
    localparam int TW = tlc_pkg::TW;
    localparam int L  = tlc_pkg::LAT;

    // ------------------------------------------------------------
    // saturating arithmetic
    // ------------------------------------------------------------
    function automatic logic [DW-1:0] mulsat(logic [DW-1:0] a,
                                             logic [DW-1:0] b, int sh);
        logic [2*DW-1:0] p;
        p = (a * b) >> sh;
        return (|p[2*DW-1:DW]) ? tlc_pkg::SAT16 : p[DW-1:0];
    endfunction
    function automatic logic [DW-1:0] addsat(logic [DW-1:0] a,
                                             logic [DW-1:0] b);
        logic [DW:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[DW] ? tlc_pkg::SAT16 : s[DW-1:0];
    endfunction
    // loss in power units, never above the positive reading limit
    function automatic logic [PW-1:0] lossmul(logic [DW-1:0] s,
                                              logic [DW-1:0] f);
        logic [2*DW-1:0] p;
        p = (s * f) >> tlc_pkg::FRAC;
        return (|p[2*DW-1:PW-1]) ? {1'b0, {(PW-1){1'b1}}}
                                 : {1'b0, p[PW-2:0]};
    endfunction
    function automatic logic [PW-1:0] applyc(logic [PW-1:0] w,
                                             logic [PW-1:0] l, logic up);
        logic [PW:0] s;
        s = up ? {w[PW-1], w} + {1'b0, l} : {w[PW-1], w} - {1'b0, l};
        if (s[PW] != s[PW-1])
            return s[PW] ? {1'b1, {(PW-1){1'b0}}} : {1'b0, {(PW-1){1'b1}}};
        return s[PW-1:0];
    endfunction

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [tlc_pkg::C_BITS-1:0] ctrl_r;
    logic [DW-1:0] iron_w_r, copper_w_r, iron_v_r, copper_v_r;
    logic [DW-1:0] recip_v_r, recip_i_r, fsva_r, count_r, rdata_r;

    // fixed-point config; coefficients reset to zero so nothing is
    // added until software has loaded them
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ctrl_r     <= tlc_pkg::CTRL_RST;
            iron_w_r   <= tlc_pkg::ZERO_W;
            copper_w_r <= tlc_pkg::ZERO_W;
            iron_v_r   <= tlc_pkg::ZERO_W;
            copper_v_r <= tlc_pkg::ZERO_W;
            recip_v_r  <= tlc_pkg::RECIP_RST;
            recip_i_r  <= tlc_pkg::RECIP_RST;
            fsva_r     <= tlc_pkg::ZERO_W;
        end else if (reg_wr) begin
            case (reg_addr)
                tlc_pkg::A_CTRL:     ctrl_r <= reg_wdata[tlc_pkg::C_BITS-1:0];
                tlc_pkg::A_IRON_W:   iron_w_r   <= reg_wdata;
                tlc_pkg::A_COPPER_W: copper_w_r <= reg_wdata;
                tlc_pkg::A_IRON_V:   iron_v_r   <= reg_wdata;
                tlc_pkg::A_COPPER_V: copper_v_r <= reg_wdata;
                tlc_pkg::A_RECIP_V:  recip_v_r  <= reg_wdata;
                tlc_pkg::A_RECIP_I:  recip_i_r  <= reg_wdata;
                tlc_pkg::A_FSVA:     fsva_r     <= reg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rdata_r <= tlc_pkg::ZERO_W;
        end else if (reg_rd) begin
            case (reg_addr)
                tlc_pkg::A_CTRL:     rdata_r <= {{(DW-tlc_pkg::C_BITS){1'b0}},
                                                 ctrl_r};
                tlc_pkg::A_IRON_W:   rdata_r <= iron_w_r;
                tlc_pkg::A_COPPER_W: rdata_r <= copper_w_r;
                tlc_pkg::A_IRON_V:   rdata_r <= iron_v_r;
                tlc_pkg::A_COPPER_V: rdata_r <= copper_v_r;
                tlc_pkg::A_RECIP_V:  rdata_r <= recip_v_r;
                tlc_pkg::A_RECIP_I:  rdata_r <= recip_i_r;
                tlc_pkg::A_FSVA:     rdata_r <= fsva_r;
                tlc_pkg::A_STATUS:   rdata_r <= count_r;
                default:             rdata_r <= tlc_pkg::ZERO_W;
            endcase
        end else begin
            rdata_r <= tlc_pkg::ZERO_W;
        end
    end
    assign reg_rdata = rdata_r;

    // ------------------------------------------------------------
    // pipeline side fields, one slot per stage
    // ------------------------------------------------------------
    // control bits are captured with the reading, but coefficient registers are read
    // live at later stages, so a write mid-flight can mix two configurations in one result
    logic          vld_r [1:L];
    logic [1:0]    ph_r  [1:L];
    logic          lst_r [1:L];
    logic          byp_r [1:L];
    logic          fe_r  [1:L];
    logic          cu_r  [1:L];
    logic          up_r  [1:L];
    logic [PW-1:0] rw_r  [1:L];
    logic [PW-1:0] rv_r  [1:L];

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            for (int k = 1; k <= L; k++) begin
                vld_r[k] <= 1'b0;
                ph_r[k]  <= '0;
                lst_r[k] <= 1'b0;
                byp_r[k] <= 1'b0;
                fe_r[k]  <= 1'b0;
                cu_r[k]  <= 1'b0;
                up_r[k]  <= 1'b0;
                rw_r[k]  <= '0;
                rv_r[k]  <= '0;
            end
        end else begin
            vld_r[1] <= in_valid;
            ph_r[1]  <= in_phase;
            lst_r[1] <= in_last;
            byp_r[1] <= ctrl_r[tlc_pkg::C_TEST];
            fe_r[1]  <= ctrl_r[tlc_pkg::C_IRON];
            cu_r[1]  <= ctrl_r[tlc_pkg::C_COPPER];
            // selected op on received flow; a flipped direction makes
            // negative readings the received ones
            up_r[1]  <= ctrl_r[tlc_pkg::C_ADD] ^ ctrl_r[tlc_pkg::C_FLIP];
            rw_r[1]  <= in_watts;
            rv_r[1]  <= in_vars;
            for (int k = 2; k <= L; k++) begin
                vld_r[k] <= vld_r[k-1];
                ph_r[k]  <= ph_r[k-1];
                lst_r[k] <= lst_r[k-1];
                byp_r[k] <= byp_r[k-1];
                fe_r[k]  <= fe_r[k-1];
                cu_r[k]  <= cu_r[k-1];
                up_r[k]  <= up_r[k-1];
                rw_r[k]  <= rw_r[k-1];
                rv_r[k]  <= rv_r[k-1];
            end
        end
    end

    // ------------------------------------------------------------
    // loss arithmetic
    // ------------------------------------------------------------
    logic [DW-1:0] ratv_r, rati_r, ratv2_r, rati2_r, ratv4_r, rati2b_r;
    logic [PW-1:0] wloss_r, owat_r, ovar_r;
    logic [DW-1:0] wfe, wcu, vfe, vcu;

    // disabled terms weigh zero; q2.14 ratios saturate near four
    assign wfe = fe_r[2] ? mulsat(ratv2_r, iron_w_r, tlc_pkg::CFRAC) : '0;
    assign wcu = cu_r[2] ? mulsat(rati2_r, copper_w_r, tlc_pkg::CFRAC) : '0;
    assign vfe = fe_r[3] ? mulsat(ratv4_r, iron_v_r, tlc_pkg::CFRAC) : '0;
    assign vcu = cu_r[3] ? mulsat(rati2b_r, copper_v_r, tlc_pkg::CFRAC) : '0;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ratv_r   <= '0;
            rati_r   <= '0;
            ratv2_r  <= '0;
            rati2_r  <= '0;
            ratv4_r  <= '0;
            rati2b_r <= '0;
            wloss_r  <= '0;
            owat_r   <= '0;
            ovar_r   <= '0;
        end else begin
            ratv_r   <= mulsat(in_volts, recip_v_r, tlc_pkg::FRAC);
            rati_r   <= mulsat(in_amps, recip_i_r, tlc_pkg::FRAC);
            ratv2_r  <= mulsat(ratv_r, ratv_r, tlc_pkg::FRAC);
            rati2_r  <= mulsat(rati_r, rati_r, tlc_pkg::FRAC);
            ratv4_r  <= mulsat(ratv2_r, ratv2_r, tlc_pkg::FRAC);
            rati2b_r <= rati2_r;
            wloss_r  <= lossmul(addsat(wfe, wcu), fsva_r);
            if (byp_r[3]) begin
                owat_r <= rw_r[3];
                ovar_r <= rv_r[3];
            end else begin
                // same sign rule both ways through the meter
                owat_r <= applyc(rw_r[3], wloss_r, up_r[3]);
                ovar_r <= applyc(rv_r[3], lossmul(addsat(vfe, vcu), fsva_r),
                                 up_r[3]);
            end
        end
    end
    // corrected readings (raw ones in test mode) are the only copy handed downstream
    assign out_valid = vld_r[L];
    assign out_phase = ph_r[L];
    assign out_last  = lst_r[L];
    assign out_watts = owat_r;
    assign out_vars  = ovar_r;

    // ------------------------------------------------------------
    // phase totals and sample count
    // ------------------------------------------------------------
    logic [TW-1:0] accw_r, accv_r, totw_r, totv_r, sumw, sumv;
    logic          totv_vld_r;
    assign sumw = accw_r + {{(TW-PW){owat_r[PW-1]}}, owat_r};
    assign sumv = accv_r + {{(TW-PW){ovar_r[PW-1]}}, ovar_r};

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            accw_r     <= '0;
            accv_r     <= '0;
            totw_r     <= '0;
            totv_r     <= '0;
            totv_vld_r <= 1'b0;
            count_r    <= '0;
        end else begin
            totv_vld_r <= vld_r[L] && lst_r[L];
            if (vld_r[L]) begin
                count_r <= count_r + 16'h0001;
                accw_r  <= lst_r[L] ? '0 : sumw;
                accv_r  <= lst_r[L] ? '0 : sumv;
                if (lst_r[L]) begin
                    totw_r <= sumw;
                    totv_r <= sumv;
                end
            end
        end
    end
    assign tot_valid = totv_vld_r;
    assign tot_watts = totw_r;
    assign tot_vars  = totv_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_fixed_latency: assert property (in_valid |-> ##4 out_valid)
        else $error("reading did not appear four cycles later");
    a_phase_kept: assert property (in_valid |-> ##4 out_phase ==
                                   $past(in_phase, 4))
        else $error("phase index changed in flight");
    a_test_bypass: assert property (in_valid && ctrl_r[tlc_pkg::C_TEST]
        |-> ##4 (out_watts == $past(in_watts, 4) &&
                 out_vars == $past(in_vars, 4)))
        else $error("test mode altered a reading");
    a_terms_off: assert property (vld_r[L] && !fe_r[L] && !cu_r[L]
        |-> owat_r == rw_r[L] && ovar_r == rv_r[L])
        else $error("reading changed with both terms off");
    a_sign_up: assert property (vld_r[L] && up_r[L] && !byp_r[L]
        |-> $signed(owat_r) >= $signed(rw_r[L]))
        else $error("loss not added toward received side");
    a_sign_down: assert property (vld_r[L] && !up_r[L] && !byp_r[L]
        |-> $signed(owat_r) <= $signed(rw_r[L]))
        else $error("loss not taken from received side");
    a_loss_sat: assert property (!wloss_r[PW-1])
        else $error("watt loss wrapped negative");
    a_zero_fsva: assert property (fsva_r == '0 && $stable(fsva_r)
        |=> wloss_r == '0)
        else $error("loss nonzero with zero full-scale va");
    a_total_after: assert property (vld_r[L] && lst_r[L]
        |=> tot_valid && tot_watts == $past(sumw))
        else $error("phase total missing after last phase");
    c_compensate: cover property (vld_r[L] && !byp_r[L] && fe_r[L]
                                  && cu_r[L]);
    c_bypass: cover property (vld_r[L] && byp_r[L]);
    c_delivered: cover property (vld_r[L] && !byp_r[L] && rw_r[L][PW-1]);
    c_total: cover property (tot_valid);
endmodule // tlc_core

//--- bench/tlc_meas_model.sv
// model of the per-phase measurement engine feeding the datapath
// assumes callers enter its tasks just after a rising mclk edge
`timescale 1ns/1ps
module tlc_meas_model (
    input  wire logic        mclk,
    output logic             in_valid,
    output logic [1:0]       in_phase,
    output logic             in_last,
    output logic [15:0]      in_volts,
    output logic [15:0]      in_amps,
    output logic [23:0]      in_watts,
    output logic [23:0]      in_vars
);
    initial begin
        in_valid = 1'b0;
        in_phase = 2'h0;
        in_last  = 1'b0;
        in_volts = 16'h0000;
        in_amps  = 16'h0000;
        in_watts = 24'h000000;
        in_vars  = 24'h000000;
    end

    // one phase reading per call, last marks the end of a set
    task automatic send(input logic [1:0] ph, input logic lst,
                        input logic [15:0] v, a,
                        input logic [23:0] w, r);
        in_valid <= 1'b1;
        in_phase <= ph;
        in_last  <= lst;
        in_volts <= v;
        in_amps  <= a;
        in_watts <= w;
        in_vars  <= r;
        @(posedge mclk);
    endtask

    // no pull on these lines, so idle shows the inverse of the last value
    task automatic idle();
        in_valid <= 1'b0;
        in_phase <= ~in_phase;
        in_last  <= ~in_last;
        in_volts <= ~in_volts;
        in_amps  <= ~in_amps;
        in_watts <= ~in_watts;
        in_vars  <= ~in_vars;
    endtask
endmodule // tlc_meas_model

//--- bench/tb_top.sv
// self-checking bench for the loss compensation datapath
// assumes the measurement model drives the reading stream
`timescale 1ns/1ps
module tb_top;
    logic        mclk      = 1'b0;
    logic        nrst      = 1'b0;
    logic [3:0]  reg_addr  = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic        rd_seen   = 1'b0;
    wire  logic [15:0] reg_rdata, in_volts, in_amps;
    wire  logic [23:0] in_watts, in_vars, out_watts, out_vars;
    wire  logic [25:0] tot_watts, tot_vars;
    wire  logic [1:0]  in_phase, out_phase;
    wire  logic        in_valid, in_last, out_valid, out_last, tot_valid;
    int          fails = 0, checks_done = 0, cyc = 0, seed = 32'hFCFE;
    logic [15:0] cfg [0:7];
    logic [15:0] outs;
    logic [25:0] acc_w, acc_v;
    logic [15:0] rq[$];
    logic [66:0] oq[$];
    logic [51:0] tq[$];

    tlc_meas_model pm (.mclk(mclk), .in_valid(in_valid), .in_phase(in_phase),
        .in_last(in_last), .in_volts(in_volts), .in_amps(in_amps),
        .in_watts(in_watts), .in_vars(in_vars));
    tlc_core uut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .in_valid(in_valid), .in_phase(in_phase),
        .in_last(in_last), .in_volts(in_volts), .in_amps(in_amps),
        .in_watts(in_watts), .in_vars(in_vars), .out_valid(out_valid),
        .out_phase(out_phase), .out_last(out_last), .out_watts(out_watts),
        .out_vars(out_vars), .tot_valid(tot_valid), .tot_watts(tot_watts),
        .tot_vars(tot_vars));

    always #20 mclk = ~mclk;

    // ----------------------------------------
    // comparison and verdict
    // ----------------------------------------
    task automatic chk(input logic [79:0] e, g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic cmp_rd(input logic [15:0] e, g); chk(80'(e), 80'(g));
    endtask
    task automatic cmp_out(input logic [66:0] e, g); chk(80'(e), 80'(g));
    endtask
    task automatic cmp_tot(input logic [51:0] e, g); chk(80'(e), 80'(g));
    endtask
    task automatic close_out();
        // a result that never came leaves its note behind: count it
        if (rq.size() != 0 || oq.size() != 0 || tq.size() != 0) fails++;
        if (fails == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // monitor: oldest note against each result as it appears
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        rd_seen <= reg_rd;
        if (rd_seen) cmp_rd(rq.pop_front(), reg_rdata);
        if (out_valid) cmp_out(oq.pop_front(), {cyc[15:0], out_phase,
            out_last, out_watts, out_vars});
        if (tot_valid) cmp_tot(tq.pop_front(), {tot_watts, tot_vars});
        if (cyc == 5000) begin
            fails++;
            close_out();
        end
    end

    // ----------------------------------------
    // reference arithmetic and drivers
    // ----------------------------------------
    function automatic logic [15:0] sat16(input logic [47:0] x);
        return (x > 48'h00000000FFFF) ? 16'hFFFF : x[15:0];
    endfunction
    function automatic logic [23:0] corr(input logic [15:0] v, a,
                                         input logic [23:0] p, input logic q);
        logic [15:0] rv, ri, v2, i2, fe, cu, sm;
        logic [47:0] ls;
        logic signed [25:0] s;
        if (cfg[0][4]) return p;
        rv = sat16((48'(v) * cfg[5]) >> 14);
        ri = sat16((48'(a) * cfg[6]) >> 14);
        v2 = sat16((48'(rv) * rv) >> 14);
        i2 = sat16((48'(ri) * ri) >> 14);
        fe = q ? sat16((48'(sat16((48'(v2) * v2) >> 14)) * cfg[3]) >> 16)
               : sat16((48'(v2) * cfg[1]) >> 16);
        cu = sat16((48'(i2) * (q ? cfg[4] : cfg[2])) >> 16);
        sm = sat16(48'(cfg[0][0] ? fe : 16'h0000)
                   + 48'(cfg[0][1] ? cu : 16'h0000));
        ls = (48'(sm) * cfg[7]) >> 14;
        if (ls > 48'h7FFFFF) ls = 48'h7FFFFF;
        if (cfg[0][2] ^ cfg[0][3])
            s = $signed({{2{p[23]}}, p}) + $signed({3'h0, ls[22:0]});
        else
            s = $signed({{2{p[23]}}, p}) - $signed({3'h0, ls[22:0]});
        if (s > 26'sh07FFFFF) return 24'h7FFFFF;
        if (s < -26'sh0800000) return 24'h800000;
        return s[23:0];
    endfunction
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        if (a == 4'h0) cfg[0] = {11'h000, d[4:0]};
        else if (a < 4'h8) cfg[a[2:0]] = d;
    endtask
    task automatic rd(input logic [3:0] a);
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        reg_addr <= a;
        @(posedge mclk);
        rq.push_back(a < 4'h8 ? cfg[a[2:0]] : (a == 4'h8 ? outs : 16'h0000));
    endtask
    task automatic bus_idle();
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask
    task automatic rdg(input logic [1:0] ph, input logic lst,
                       input logic [15:0] v, a, input logic [23:0] w, r);
        logic [23:0] ew, ev;
        ew = corr(v, a, w, 1'b0);
        ev = corr(v, a, r, 1'b1);
        pm.send(ph, lst, v, a, w, r);
        oq.push_back({16'(cyc + 4), ph, lst, ew, ev});
        outs = outs + 16'h0001;
        acc_w = acc_w + {{2{ew[23]}}, ew};
        acc_v = acc_v + {{2{ev[23]}}, ev};
        if (lst) begin
            tq.push_back({acc_w, acc_v});
            acc_w = 26'h0000000;
            acc_v = 26'h0000000;
        end
    endtask
    // reset defaults, refused writes, unmapped reads return zero
    task automatic start_up();
        cfg = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                16'h4000, 16'h4000, 16'h0000};
        outs = 16'h0000;
        acc_w = 26'h0000000;
        acc_v = 26'h0000000;
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
        cmp_out(67'h0, {16'h0000, out_phase, out_last, out_watts,
                        out_vars});
        wr(4'h8, 16'hFFFF);
        wr(4'hC, 16'hFFFF);
        for (int k = 0; k < 16; k++) rd(4'(k));
        bus_idle();
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] rw, rx;
        repeat (8) @(posedge mclk);
        start_up();
        for (int i = 0; i < 32; i++) begin
            if (i % 8 == 0) begin
                // pipeline reads coefficients late, so change them idle
                repeat (6) @(posedge mclk);
                for (int k = 1; k < 8; k++) begin
                    rw = $random(seed);
                    // calibration kept near unity as a normalised set
                    wr(4'(k), (k == 5 || k == 6) ? 16'h3000 + (rw[15:0] & 16'h1FFF)
                                                 : rw[15:0]);
                end
            end
            wr(4'h0, 16'(i));
            bus_idle();
            for (int p = 0; p < 3; p++) begin
                rw = $random(seed);
                rx = $random(seed);
                if (p == 0) rdg(2'h0, 1'b0, rw[15:0], rw[31:16],
                                24'h7FFFFF, 24'h800000);
                else rdg(2'(p), p == 2, 16'h2000 + (rw[15:0] & 16'h3FFF),
                         p == 1 ? rw[31:16] : 16'h2000 + (rw[31:16] & 16'h3FFF),
                         rx[23:0], {rx[31:24], rw[15:0]});
            end
            pm.idle();
            if (i == 15) begin
                repeat (6) @(posedge mclk);
                rd(4'h8);
                bus_idle();
            end
        end
        repeat (6) @(posedge mclk);
        for (int k = 0; k < 8; k++) rd(4'(k));
        bus_idle();
        repeat (2) @(posedge mclk);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        start_up();
        repeat (4) @(posedge mclk);
        close_out();
    end
endmodule // tb_top
